// ### core/spims_pkg.sv
// Purpose: constants shared by the serial port shifter
// Assumes: APB word addressing, byte address = 4 * register index
// Notes:   field positions of both control registers live here
package spims_pkg;
	// ------------------------------------------------------------
	// register indices and byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_CONTROL = 8'h10;
	localparam logic [7:0] IDX_STATUS  = 8'h11;
	localparam logic [7:0] IDX_DATA    = 8'h12;
	localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
	localparam logic [9:0] ADDR_STATUS  = {IDX_STATUS, 2'b00};
	localparam logic [9:0] ADDR_DATA    = {IDX_DATA, 2'b00};
	// ------------------------------------------------------------
	// serial_port_control fields
	// ------------------------------------------------------------
	localparam int CTL_RX_IE    = 7;
	localparam int CTL_MASTER   = 5;
	localparam int CTL_CLOCK_POLARITY_BIT     = 4;
	localparam int CTL_CLOCK_PHASE_BIT     = 3;
	localparam int CTL_ENABLE   = 1;
	localparam int CTL_TX_IE    = 0;
	localparam logic [7:0] CTL_MASK  = 8'hBB;
	localparam logic [7:0] CTL_RESET = 8'h28;
	// ------------------------------------------------------------
	// serial_port_status_control fields
	// ------------------------------------------------------------
	localparam int STS_RX_FULL  = 7;
	localparam int STS_ERR_IE   = 6;
	localparam int STS_OVERRUN  = 5;
	localparam int STS_MODE_F   = 4;
	localparam int STS_TX_EMPTY = 3;
	localparam int STS_MF_EN    = 2;
	localparam logic [7:0] STS_WR_MASK = 8'h47;
	localparam logic [7:0] STS_RESET   = 8'h08;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int BITS_PER_FRAME = 8;
	localparam logic [3:0] LAST_EDGE = 4'hF;
	localparam logic [2:0] LAST_BIT  = 3'h7;
	localparam logic [2:0] BIT1_IDX  = 3'h6;
	localparam logic [6:0] HALF_DIV2   = 7'h01;
	localparam logic [6:0] HALF_DIV8   = 7'h04;
	localparam logic [6:0] HALF_DIV32  = 7'h10;
	localparam logic [6:0] HALF_DIV128 = 7'h40;
endpackage

// ### core/spims_shifter.sv
// Purpose: full-duplex serial port, master or slave, with APB registers
// Assumes: pclk 100 MHz; pins come in asynchronous and are synchronised
// Notes:   slave clock must stay well below pclk because of synchronising
//
// Operation
// [RULE1] master-select bit set means master, clear means slave
// [RULE2] only a master starts; a data register write starts it
// [RULE3] byte written while shifter empty moves in, transmit-empty sets
// [RULE4] byte shifts out while peer byte shifts in together
// [RULE5] two rate bits pick div 2, 8, 32 or 128 serial clock
// [RULE6] receive-full sets at transfer end, byte moves to receive reg
// [RULE7] receive-full clears after status read then data read
// [RULE8] separate transmit and receive registers share one shifter
// [RULE9] receive and transmit interrupts enabled apart, errors too
// [RULE10] slave takes shift clock from the serial clock pin
// [RULE11] external master holds select low for the whole transfer
// [RULE12] slave copies full byte to receive reg, sets receive-full
// [RULE13] external master may clock a slave up to bus rate; here the synchronisers need sclk well below pclk
// [RULE14] slave shifts out on master-in line once transfer starts
// [RULE15] slave byte written a cycle early goes out, else old shifter
// [RULE16] byte written during transfer waits until transfer ends
// [RULE17] slave starts on first clock edge or select fall by phase
// [RULE18] serial clock idles correctly before the slave is enabled
// [RULE19] set roles first, enable master first, disable slave first
// [RULE20] phase clear: select toggles per byte; phase set: may stay low
// [RULE21] overrun sets if receive unread at bit 1, new byte dropped
// [RULE22] master clock runs only with enable and master-select set
// [RULE23] eight bits, msb first, shift one edge, sample the other
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
module spims_shifter
	import spims_pkg::*;
#(
	parameter int ADDR_W = 10
)(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              sclk_in,
	output logic                   sclk_out,
	output logic                   sclk_oe,
	input  wire logic              mosi_in,
	output logic                   mosi_out,
	output logic                   mosi_oe,
	input  wire logic              miso_in,
	output logic                   miso_out,
	output logic                   miso_oe,
	input  wire logic              ss_n_in,
	output logic                   rx_irq,
	output logic                   tx_irq
);
	// refuse an address bus too narrow for the register decoder
	if (ADDR_W < 10)
	begin : g_addr_w_check
		$error("spims_shifter: ADDR_W must be at least 10");
	end

	// half serial period in pclk cycles for a rate code
	function automatic logic [6:0] half_period(input logic [1:0] code);
		case (code)
			2'b00: half_period = HALF_DIV2;
			2'b01: half_period = HALF_DIV8;
			2'b10: half_period = HALF_DIV32;
			default: half_period = HALF_DIV128;
		endcase
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:0] control;
	logic [7:0] status;
	logic [7:0] tx_buf;
	logic [7:0] rx_data;
	logic [7:0] shreg;
	logic       out_bit;
	logic       busy;
	logic [3:0] edge_cnt;
	logic [2:0] bit_cnt;
	logic [6:0] div_cnt;
	logic       drop;
	logic       rx_armed;
	logic       mf_armed;
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic       sclk_d;
	logic       ss_d;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	wire [9:0] word_addr = paddr[9:0];
	wire setup_ph  = psel && !penable;
	wire access_ph = psel && penable && pready;
	wire hit_ctl = word_addr == ADDR_CONTROL;
	wire hit_sts = word_addr == ADDR_STATUS;
	wire hit_dat = word_addr == ADDR_DATA;
	wire hit_any = hit_ctl || hit_sts || hit_dat;
	wire wr_ctl  = access_ph && pwrite && hit_ctl;
	wire wr_sts  = access_ph && pwrite && hit_sts;
	wire wr_dat  = access_ph && pwrite && hit_dat;
	wire rd_sts  = access_ph && !pwrite && hit_sts;
	wire rd_dat  = access_ph && !pwrite && hit_dat;
	wire [7:0] rd_mux = hit_ctl ? control :
		hit_sts ? status : hit_dat ? rx_data : 8'h00;

	// ------------------------------------------------------------
	// configuration view
	// ------------------------------------------------------------
	wire is_master = control[CTL_MASTER];
	wire enabled   = control[CTL_ENABLE];
	wire clock_polarity_bit      = control[CTL_CLOCK_POLARITY_BIT];
	wire clock_phase_bit      = control[CTL_CLOCK_PHASE_BIT];
	wire run_m     = enabled && is_master;
	wire run_s     = enabled && !is_master;
	wire rx_full   = status[STS_RX_FULL];
	wire tx_empty  = status[STS_TX_EMPTY];

	// synchronised pins: 0 sclk, 1 ss_n, 2 mosi, 3 miso
	wire sclk_s = sync2[0];
	wire ss_s   = sync2[1];
	wire in_bit = is_master ? sync2[3] : sync2[2];

	// ------------------------------------------------------------
	// master rate generator and edges
	// ------------------------------------------------------------
	wire [6:0] half = half_period({status[1], status[0]});
	wire tick = run_m && (div_cnt == half - 7'h01); // RULE5
	wire m_lead   = !edge_cnt[0];
	wire m_sample = tick && busy && (m_lead ^ clock_phase_bit);
	wire m_shift  = tick && busy && !(m_lead ^ clock_phase_bit);
	wire m_start  = run_m && !busy && !tx_empty; // RULE2

	// ------------------------------------------------------------
	// slave edges from the pin clock
	// ------------------------------------------------------------
	wire s_edge  = run_s && !ss_s && (sclk_s != sclk_d); // RULE10
	wire s_lead  = s_edge && (sclk_s != clock_polarity_bit);
	wire s_trail = s_edge && (sclk_s == clock_polarity_bit);
	wire s_start = run_s && !busy && (clock_phase_bit ? s_lead
		: (!ss_s && ss_d)); // RULE17
	wire s_sample = busy && (clock_phase_bit ? s_trail : s_lead);
	wire s_shift  = busy && (clock_phase_bit ? s_lead : s_trail);

	// ------------------------------------------------------------
	// shared engine events
	// ------------------------------------------------------------
	wire start_ev  = m_start || s_start;
	wire sample_ev = m_sample || s_sample;
	wire shift_ev  = m_shift || s_shift;
	wire m_done = tick && busy && edge_cnt == LAST_EDGE;
	wire s_done = s_sample && bit_cnt == LAST_BIT;
	wire done_ev = m_done || s_done;
	wire [7:0] rx_byte = sample_ev ? {shreg[6:0], in_bit} : shreg;
	// slave reuses old shifter contents when no byte waits
	wire [7:0] load_byte = tx_empty ? shreg : tx_buf; // RULE15
	wire ovr_ev  = sample_ev && bit_cnt == BIT1_IDX && rx_full; // RULE21
	wire mf_m = run_m && !ss_s && status[STS_MF_EN];
	wire mf_s = run_s && busy && ss_s && status[STS_MF_EN];
	wire mf_ev = mf_m || mf_s;
	wire deliver = done_ev && !drop && !ovr_ev; // RULE6 RULE12

	// ------------------------------------------------------------
	// input synchronisers and edge history
	// ------------------------------------------------------------
	// the first stage feeds only the second, history reads stage two
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1  <= 4'hF;
			sync2  <= 4'hF;
			sclk_d <= 1'b1; // matches stage two, no false edge
			ss_d   <= 1'b1;
		end
		else
		begin
			sync1  <= {miso_in, mosi_in, ss_n_in, sclk_in};
			sync2  <= sync1;
			sclk_d <= sync2[0];
			ss_d   <= sync2[1];
		end
	end

	// ------------------------------------------------------------
	// APB slave: one setup cycle, answer in the access cycle
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= setup_ph;
			pslverr <= setup_ph && !hit_any;
			if (setup_ph)
				prdata <= {24'h00_0000, rd_mux};
		end
	end

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	// mode fault drops master role so two masters never fight
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			control <= CTL_RESET;
		else if (mf_m)
			control <= control & ~(8'h01 << CTL_MASTER);
		else if (wr_ctl)
			control <= pwdata[7:0] & CTL_MASK; // RULE1
		else if (wr_dat)
			control <= control & ~(8'h01 << CTL_TX_IE);
	end

	// ------------------------------------------------------------
	// status flags; a hardware set wins over a software clear
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			status   <= STS_RESET;
			rx_armed <= 1'b0;
			mf_armed <= 1'b0;
		end
		else
		begin
			if (wr_sts)
			begin
				status[STS_ERR_IE] <= pwdata[STS_ERR_IE];
				status[STS_MF_EN]  <= pwdata[STS_MF_EN];
				status[1:0]        <= pwdata[1:0];
			end
			if (rd_sts)
				rx_armed <= rx_full || status[STS_OVERRUN];
			else if (rd_dat)
				rx_armed <= 1'b0;
			if (rd_sts)
				mf_armed <= status[STS_MODE_F];
			else if (wr_ctl)
				mf_armed <= 1'b0;
			// two-step clear of receive-full and overrun
			if (deliver)
				status[STS_RX_FULL] <= 1'b1; // RULE6
			else if (rd_dat && rx_armed)
				status[STS_RX_FULL] <= 1'b0; // RULE7
			if (ovr_ev)
				status[STS_OVERRUN] <= 1'b1; // RULE21
			else if (rd_dat && rx_armed)
				status[STS_OVERRUN] <= 1'b0;
			if (mf_ev)
				status[STS_MODE_F] <= 1'b1;
			else if (wr_ctl && mf_armed)
				status[STS_MODE_F] <= 1'b0;
			// buffer handed to the shifter is empty again
			if (start_ev && !tx_empty)
				status[STS_TX_EMPTY] <= 1'b1; // RULE3
			else if (wr_dat)
				status[STS_TX_EMPTY] <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// transmit and receive data registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_buf  <= 8'h00;
			rx_data <= 8'h00;
		end
		else
		begin
			if (wr_dat)
				tx_buf <= pwdata[7:0]; // RULE8 RULE16
			if (deliver)
				rx_data <= rx_byte;
		end
	end

	// ------------------------------------------------------------
	// rate divider, free running only while master is enabled
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_cnt <= 7'h00;
		else if (!run_m || tick)
			div_cnt <= 7'h00; // RULE22
		else
			div_cnt <= div_cnt + 7'h01;
	end

	// ------------------------------------------------------------
	// shift engine, msb first, one shared shifter
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			shreg    <= 8'h00;
			out_bit  <= 1'b0;
			busy     <= 1'b0;
			edge_cnt <= 4'h0;
			bit_cnt  <= 3'h0;
			drop     <= 1'b0;
		end
		else if (mf_ev || !enabled)
			busy <= 1'b0;
		else if (start_ev)
		begin
			shreg    <= load_byte; // RULE14 RULE15
			out_bit  <= load_byte[7]; // RULE23
			busy     <= 1'b1;
			edge_cnt <= 4'h0;
			bit_cnt  <= 3'h0;
			drop     <= 1'b0;
		end
		else
		begin
			if (sample_ev)
			begin
				shreg   <= rx_byte; // RULE4
				bit_cnt <= bit_cnt + 3'h1;
			end
			if (shift_ev)
				out_bit <= shreg[7]; // RULE23
			if (tick && busy)
				edge_cnt <= edge_cnt + 4'h1;
			if (ovr_ev)
				drop <= 1'b1;
			if (done_ev)
				busy <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// pins and interrupt lines, all registered
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_out <= 1'b0;
			sclk_oe  <= 1'b0;
			mosi_out <= 1'b0;
			mosi_oe  <= 1'b0;
			miso_out <= 1'b0;
			miso_oe  <= 1'b0;
			rx_irq   <= 1'b0;
			tx_irq   <= 1'b0;
		end
		else
		begin
			if (!busy || !run_m)
				sclk_out <= clock_polarity_bit;
			else if (tick)
				sclk_out <= !sclk_out; // RULE5
			sclk_oe  <= run_m; // RULE1
			mosi_oe  <= run_m;
			mosi_out <= out_bit;
			miso_oe  <= run_s && !ss_s; // RULE14
			miso_out <= out_bit;
			rx_irq   <= (control[CTL_RX_IE] && rx_full) ||
				(status[STS_ERR_IE] && (status[STS_OVERRUN] ||
				status[STS_MODE_F])); // RULE9
			tx_irq   <= control[CTL_TX_IE] && tx_empty; // RULE9
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	chk_role_drive: assert property (@(posedge pclk) disable iff (!presetn)
		!is_master |=> !sclk_oe && !mosi_oe) // RULE1
		else $error("slave drives the clock or master-out pin");
	chk_start_master: assert property (@(posedge pclk)
		disable iff (!presetn) m_start && !mf_ev |=> busy && tx_empty)
		else $error("master load did not empty the buffer"); // RULE3
	chk_no_slave_start: assert property (@(posedge pclk)
		disable iff (!presetn) run_s && wr_dat && !busy && ss_s |=> !busy)
		else $error("data write started a slave transfer"); // RULE2
	chk_div2_rate: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && status[1:0] == 2'b00 && run_m) |=> tick || !run_m)
		else $error("div 2 rate missed a half period"); // RULE5
	chk_rx_deliver: assert property (@(posedge pclk)
		disable iff (!presetn) deliver && !mf_ev
		|=> rx_full && rx_data == $past(rx_byte))
		else $error("received byte not delivered"); // RULE6
	chk_rx_clear: assert property (@(posedge pclk) disable iff (!presetn)
		rd_dat && rx_armed && !deliver |=> !rx_full)
		else $error("receive-full not cleared"); // RULE7
	chk_ovr_bit1: assert property (@(posedge pclk) disable iff (!presetn)
		ovr_ev |=> status[STS_OVERRUN] ##0 $stable(rx_data))
		else $error("overrun lost or data replaced"); // RULE21
	chk_clock_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!run_m |=> div_cnt == 7'h00 && sclk_out == $past(clock_polarity_bit))
		else $error("master clock ran while gated"); // RULE22
	chk_tx_hold: assert property (@(posedge pclk) disable iff (!presetn)
		wr_dat && busy && !done_ev && !mf_ev |=> !tx_empty && busy)
		else $error("write during transfer not held"); // RULE16
	chk_eight_bits: assert property (@(posedge pclk) disable iff (!presetn)
		s_done |-> bit_cnt == LAST_BIT ##1 !busy)
		else $error("slave frame not eight bits"); // RULE23
	chk_miso_en: assert property (@(posedge pclk) disable iff (!presetn)
		run_s && !ss_s |=> miso_oe)
		else $error("selected slave not driving"); // RULE14
	cov_master_frame: cover property (@(posedge pclk) disable iff (!presetn)
		m_done);
	cov_slave_frame: cover property (@(posedge pclk) disable iff (!presetn)
		s_done);
	cov_overrun: cover property (@(posedge pclk) disable iff (!presetn)
		ovr_ev);
	cov_mode_fault: cover property (@(posedge pclk) disable iff (!presetn)
		mf_ev);
endmodule // spims_shifter

// ### bench/spims_peer.sv
// Purpose: far-side serial peer, acting as slave or as master
// Assumes: pclk times everything; clock_polarity_bit and clock_phase_bit match the port
// Notes:   released lines toggle so a stale bit never reads as valid
`timescale 1ns/1ns
module spims_peer #(
	parameter int HALF = 6
)(
	input  wire logic pclk,
	input  wire logic act_master,
	input  wire logic clock_polarity_bit,
	input  wire logic clock_phase_bit,
	input  wire logic sclk_w,
	input  wire logic mosi_w,
	input  wire logic miso_w,
	output logic      p_sclk,
	output logic      p_mosi,
	output logic      p_miso,
	output logic      p_ss_n
);
	logic [7:0] sr;
	logic [7:0] msr;
	logic       ld;
	logic       last_s;
	logic       junk;
	int         cnt;
	logic [7:0] rq[$];
	logic [7:0] gq[$];
	// --------------------
	// line drivers
	// --------------------
	// an idle line shows a changing level, never the last bit
	assign p_miso = (!act_master && ld) ? sr[7] : junk;
	assign p_mosi = (act_master && !p_ss_n) ? msr[7] : junk;
	initial
	begin
		ld = 1'b0;
		junk = 1'b0;
		p_ss_n = 1'b1;
		p_sclk = 1'b0;
	end
	// --------------------
	// slave role
	// --------------------
	// edges are seen one pclk late; reply reloads between frames
	always @(posedge pclk)
	begin
		junk <= ~junk;
		last_s <= sclk_w;
		if (!act_master)
			p_sclk <= clock_polarity_bit;
		if (!act_master && !ld && rq.size() > 0)
		begin
			sr <= rq.pop_front();
			ld <= 1'b1;
			cnt <= 0;
		end
		else if (!act_master && ld && sclk_w != last_s
			&& (sclk_w != clock_polarity_bit) != clock_phase_bit)
		begin
			sr <= {sr[6:0], mosi_w};
			cnt <= cnt + 1;
			if (cnt == 7)
			begin
				gq.push_back({sr[6:0], mosi_w});
				ld <= 1'b0;
			end
		end
	end
	// --------------------
	// master role
	// --------------------
	// select stays low for the whole byte and rises after it
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		int ns;
		ns = 0;
		@(posedge pclk);
		p_sclk <= clock_polarity_bit;
		msr <= tx;
		p_ss_n <= 1'b0;
		repeat (HALF) @(posedge pclk);
		for (int i = 0; i < 16; i++)
		begin
			if ((i % 2 == 0) != clock_phase_bit)
			begin
				rx = {rx[6:0], miso_w};
				ns++;
			end
			else if (ns > 0)
				msr <= msr << 1;
			p_sclk <= ~p_sclk;
			repeat (HALF) @(posedge pclk);
		end
		p_ss_n <= 1'b1;
		repeat (HALF) @(posedge pclk);
	endtask
endmodule // spims_peer

// ### bench/tb_top.sv
// Purpose: self-checking bench for the serial port shifter
// Assumes: peer model drives the far side of the serial lines
// Notes:   div2 frames check timing only; synchronisers eat margin
`timescale 1ns/1ns
module tb_top
	import spims_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic        pready, pslverr, serr, last_s;
	logic        sclk_out, sclk_oe, mosi_out, mosi_oe;
	logic        miso_out, miso_oe, rx_irq, tx_irq;
	logic        p_sclk, p_mosi, p_miso, p_ss_n, act_m, clock_polarity_bit, clock_phase_bit;
	wire         sclk_w, mosi_w, miso_w;
	logic [7:0]  got, s1, s2, m1, m2;
	logic [7:0]  exp_q[$];
	logic [7:0]  pexp[$];
	int          n_errors = 0;
	int          checked = 0;
	int          cyc = 0;
	int          half = 0;
	int          run = 0;
	int          tog = 0;
	int          n;
	// --------------------
	// wires and instances
	// --------------------
	// each line carries whichever party has its enable up
	assign sclk_w = sclk_oe ? sclk_out : p_sclk;
	assign mosi_w = mosi_oe ? mosi_out : p_mosi;
	assign miso_w = miso_oe ? miso_out : p_miso;
	spims_shifter #(.ADDR_W(10)) i_spims_shifter (
		.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sclk_in(sclk_w), .sclk_out(sclk_out),
		.sclk_oe(sclk_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
		.mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
		.miso_oe(miso_oe), .ss_n_in(p_ss_n), .rx_irq(rx_irq),
		.tx_irq(tx_irq)
	);
	spims_peer #(.HALF(6)) i_peer (
		.pclk(pclk), .act_master(act_m), .clock_polarity_bit(clock_polarity_bit), .clock_phase_bit(clock_phase_bit),
		.sclk_w(sclk_w), .mosi_w(mosi_w), .miso_w(miso_w),
		.p_sclk(p_sclk), .p_mosi(p_mosi), .p_miso(p_miso),
		.p_ss_n(p_ss_n)
	);
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// half-period meter on the master clock, and the hang limit
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		last_s <= sclk_out;
		run <= (sclk_out !== last_s) ? 1 : run + 1;
		if (sclk_out !== last_s)
		begin
			half <= run;
			tog <= tog + 1;
		end
		if (cyc == 60000)
		begin
			n_errors++;
			stop_test();
		end
	end
	// --------------------
	// tasks
	// --------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [9:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rdv = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_bit(input int b);
		int k;
		k = 0;
		do
		begin
			apb(1'b0, ADDR_STATUS, 32'h0);
			k++;
		end
		while (rdv[b] !== 1'b1 && k < 700);
		chk("status flag", 32'h1, 32'(rdv[b]));
	endtask
	// only the bench timeout ends this wait
	task automatic wait_peer(input int c);
		while (i_peer.gq.size() < c)
		begin
			@(posedge pclk);
		end
	endtask
	task automatic mframe(input logic [7:0] tx, input logic [7:0] rp);
		i_peer.rq.push_back(rp);
		exp_q.push_back(rp);
		pexp.push_back(tx);
		apb(1'b1, ADDR_DATA, {24'h0, tx});
	endtask
	// status read, data read, then the flag must be gone
	task automatic mcheck(input bit dat);
		logic [7:0] e;
		wait_bit(STS_RX_FULL);
		chk("rx_irq", 32'h1, 32'(rx_irq));
		apb(1'b0, ADDR_DATA, 32'h0);
		e = exp_q.pop_front();
		if (dat) chk("rx data", 32'(e), rdv);
		wait_peer(1);
		e = pexp.pop_front();
		got = i_peer.gq.pop_front();
		if (dat) chk("peer data", 32'(e), 32'(got));
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("rx_full", 32'h0, 32'(rdv[STS_RX_FULL]));
		// a queued byte reloads a cycle after the end, so look late
		chk("tx_empty", 32'h1, 32'(rdv[STS_TX_EMPTY]));
	endtask
	task automatic stop_test();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// --------------------
	// main sequence
	// --------------------
	initial
	begin
		n = $urandom(77162);
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = 10'h0;
		pwdata = 32'h0;
		{act_m, clock_polarity_bit, clock_phase_bit} = 3'h1;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ADDR_CONTROL, 32'h0);
		chk("control", 32'(CTL_RESET), rdv);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("status", 32'(STS_RESET), rdv);
		apb(1'b0, 10'h3F0, 32'h0);
		chk("hole err", 32'h1, 32'(serr));
		apb(1'b1, ADDR_CONTROL, 32'h29);
		repeat (2) @(posedge pclk);
		chk("tx_irq", 32'h1, 32'(tx_irq));
		$display("test registers done");
		// every rate, every polarity and phase, as master
		for (int r = 0; r < 4; r++)
		begin
			clock_polarity_bit <= r[0];
			clock_phase_bit <= r[1];
			apb(1'b1, ADDR_CONTROL, {24'h0, 3'h5, r[0], r[1], 3'h0});
			apb(1'b1, ADDR_STATUS, 32'(r));
			apb(1'b1, ADDR_CONTROL, {24'h0, 3'h5, r[0], r[1], 3'h2});
			repeat (2)
			begin
				mframe(8'($urandom), 8'($urandom));
				mcheck(r > 0);
			end
			chk("half", 32'(1 << (2 * r)), 32'(half));
			$display("test master rate %0d done", r);
		end
		apb(1'b1, ADDR_STATUS, 32'h1);
		mframe(8'hA5, 8'h3C);
		mframe(8'h5A, 8'hC3);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("tx held", 32'h0, 32'(rdv[STS_TX_EMPTY]));
		mcheck(1'b1);
		mcheck(1'b1);
		$display("test double buffer done");
		// second byte lands on an unread one and is dropped
		mframe(8'h81, 8'h7E);
		mframe(8'h18, 8'hE7);
		wait_bit(STS_OVERRUN);
		wait_peer(2);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("flags", 32'h3, 32'({rdv[STS_RX_FULL], rdv[STS_OVERRUN]}));
		apb(1'b0, ADDR_DATA, 32'h0);
		chk("kept byte", 32'h7E, rdv);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("flags off", 32'h0, 32'({rdv[STS_RX_FULL], rdv[STS_OVERRUN]}));
		exp_q.delete();
		pexp.delete();
		i_peer.gq.delete();
		$display("test overrun done");
		// slave: roles set while disabled, peer clocks the frames
		for (int p = 0; p < 2; p++)
		begin
			clock_polarity_bit <= p[0];
			clock_phase_bit <= p[0];
			apb(1'b1, ADDR_CONTROL, {24'h0, 3'h0, p[0], p[0], 3'h0});
			apb(1'b1, ADDR_CONTROL, {24'h0, 3'h0, p[0], p[0], 3'h2});
			act_m <= 1'b1;
			{s1, s2, m1, m2} = $urandom;
			apb(1'b1, ADDR_DATA, {24'h0, s1});
			fork
				i_peer.xfer(m1, got);
				begin
					repeat (40) @(posedge pclk);
					apb(1'b1, ADDR_DATA, {24'h0, s2});
				end
			join
			chk("slave out", 32'(s1), 32'(got));
			wait_bit(STS_RX_FULL);
			apb(1'b0, ADDR_DATA, 32'h0);
			chk("slave in", 32'(m1), rdv);
			i_peer.xfer(m2, got);
			chk("slave next", 32'(s2), 32'(got));
			wait_bit(STS_RX_FULL);
			apb(1'b0, ADDR_DATA, 32'h0);
			chk("slave in2", 32'(m2), rdv);
			act_m <= 1'b0;
			$display("test slave phase %0d done", p);
		end
		// master selected but port off: the clock must not run
		apb(1'b1, ADDR_CONTROL, 32'h20);
		// the clock first settles to the new idle level; let that pass
		repeat (4) @(posedge pclk);
		n = tog;
		apb(1'b1, ADDR_DATA, 32'h96);
		repeat (40) @(posedge pclk);
		chk("idle clock", 32'(n), 32'(tog));
		chk("sclk_oe", 32'h0, 32'(sclk_oe));
		$display("test clock gate done");
		stop_test();
	end
endmodule // tb_top
